// ---- rtl/bda_unit.sv ----
/*
 * Top of the decimal adjust and decrement unit: AXI4-Lite register
 * slave, a two-state sequencer and the arithmetic core.
 * Assumes one clock aclk (100 MHz) and synchronous active-low aresetn;
 * the master keeps at most one read and one write under way.
 */
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ns
module bda_unit
    import bda_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   busy,
    output logic                   done
);

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_EXEC = 1'b1
    } bda_state_t;

    bda_state_t        state_q;
    bda_state_t        state_d;

    // ************************************************************
    // Write channel holding registers
    // ************************************************************
    logic              aw_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_full_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;

    logic              aw_take;
    logic              w_take;
    logic              do_write;
    logic [31:0]       wmask;
    logic [31:0]       wbits;

    // The slave takes address and data in either order
    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready  = !w_full_q && !bvalid_q;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign do_write      = aw_full_q && w_full_q && !bvalid_q;

    // Byte strobes widened to a bit mask
    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wbits = w_data_q & wmask;

    // ************************************************************
    // Address decode
    // ************************************************************
    logic wr_cmd;
    logic wr_opnd;
    logic wr_flags;
    logic wr_status;
    logic wr_hit;

    assign wr_cmd    = do_write && (aw_addr_q == ADDR_CMD);
    assign wr_opnd   = do_write && (aw_addr_q == ADDR_OPND);
    assign wr_flags  = do_write && (aw_addr_q == ADDR_FLAGS);
    assign wr_status = do_write && (aw_addr_q == ADDR_STATUS);
    assign wr_hit    = wr_cmd || wr_opnd || wr_flags || wr_status;

    // ************************************************************
    // Software visible state
    // ************************************************************
    logic [15:0] opnd_q;
    logic [15:0] opnd_d;
    logic [7:0]  flags_q;
    logic [7:0]  flags_d;
    logic [1:0]  op_q;
    logic        done_q;
    logic        bad_q;
    logic        pulse_q;

    logic [1:0]  cmd_op;
    logic        start;
    logic        refuse;
    logic        finish;
    logic [15:0] core_res;
    logic [7:0]  core_flags;

    // A command starts only when its low byte is written
    assign cmd_op = w_data_q[CMD_OP_LSB +: 2];
    assign start  = wr_cmd && w_strb_q[0] && (state_q == ST_IDLE)
                  && (cmd_op != OP_ILLEGAL);
    assign refuse = wr_cmd && w_strb_q[0] && (cmd_op == OP_ILLEGAL);
    assign finish = (state_q == ST_EXEC);

    // ************************************************************
    // Arithmetic core
    // ************************************************************
    bda_core u_core (
        .op        (bda_op_t'(op_q)),
        .opnd      (opnd_q),
        .flags_in  (flags_q),
        .result    (core_res),
        .flags_out (core_flags)
    );

    // ************************************************************
    // Next values of operand and flags
    // ************************************************************
    // The finishing operation wins over a software write in that cycle,
    // since the write-back is what the command promised
    always_comb begin
        opnd_d  = opnd_q;
        flags_d = flags_q;
        if (finish) begin
            opnd_d  = core_res;
            flags_d = core_flags;
        end else begin
            if (wr_opnd) begin
                opnd_d = (opnd_q & ~wmask[15:0]) | wbits[15:0];
            end
            if (wr_flags) begin
                flags_d = ((flags_q & ~wmask[7:0]) | wbits[7:0])
                        & FLAGS_MASK;
            end
        end
    end

    // Sequencer: one cycle of work per command
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
            opnd_q  <= OPND_RST;
            flags_q <= FLAGS_RST;
            op_q    <= OP_DECIMAL_ADJUST;
        end else begin
            state_q <= state_d;
            opnd_q  <= opnd_d;
            flags_q <= flags_d;
            if (start) begin
                op_q <= cmd_op;
            end
        end
    end

    // Sticky status: a set in the same cycle beats a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q  <= 1'b0;
            bad_q   <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            done_q  <= finish
                    || (done_q && !(wr_status && wbits[ST_DONE]));
            bad_q   <= refuse
                    || (bad_q && !(wr_status && wbits[ST_BAD]));
            pulse_q <= finish;
        end
    end

    assign busy = (state_q == ST_EXEC);
    assign done = pulse_q;

    // ************************************************************
    // Write channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_full_q  <= 1'b0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (aw_take) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_q <= 1'b0;
            end
            if (w_take) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // Response stands until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ************************************************************
    // Read channel
    // ************************************************************
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        ar_take;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [31:0] status_word;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rvalid_q;

    assign status_word = (32'(busy)   << ST_BUSY)
                       | (32'(done_q) << ST_DONE)
                       | (32'(bad_q)  << ST_BAD);

    // Read mux; unused bits read as zero
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            ADDR_CMD:    rd_word = 32'(op_q);
            ADDR_OPND:   rd_word = 32'(opnd_q);
            ADDR_FLAGS:  rd_word = 32'(flags_q);
            ADDR_STATUS: rd_word = status_word;
            default:     rd_hit  = 1'b0;
        endcase
    end

    // Data are caught at the address edge and held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule

// ---- pkg/bda_pkg.sv ----
/*
 * Shared constants of the decimal adjust and decrement unit: register
 * offsets, field positions, operation codes and correction constants.
 * Assumes a single 100 MHz clock domain and a 32-bit AXI4-Lite slave.
 */
package bda_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  ADDR_CMD     = 8'h00;
    localparam logic [7:0]  ADDR_OPND    = 8'h04;
    localparam logic [7:0]  ADDR_FLAGS   = 8'h08;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0C;

    // ************************************************************
    // Field layouts and reset values
    // ************************************************************
    localparam int          CMD_OP_LSB   = 0;
    localparam int          FLG_C        = 7;
    localparam int          FLG_Z        = 6;
    localparam int          FLG_S        = 5;
    localparam int          FLG_V        = 4;
    localparam int          FLG_D        = 3;
    localparam int          FLG_H        = 2;
    localparam logic [7:0]  FLAGS_MASK   = 8'hFC;
    localparam int          ST_BUSY      = 0;
    localparam int          ST_DONE      = 1;
    localparam int          ST_BAD       = 2;
    localparam logic [7:0]  FLAGS_RST    = 8'h00;
    localparam logic [15:0] OPND_RST     = 16'h0000;

    // ************************************************************
    // Operations and arithmetic constants
    // ************************************************************
    typedef enum logic [1:0] {
        OP_DECIMAL_ADJUST    = 2'b00,
        OP_BYTE_MINUS_ONE_OP = 2'b01,
        OP_WORD_MINUS_ONE_OP = 2'b10
    } bda_op_t;
    localparam logic [1:0]  OP_ILLEGAL   = 2'b11;

    localparam logic [3:0]  DIGIT_MAX    = 4'h9;
    localparam logic [7:0]  ADJ_NONE     = 8'h00;
    localparam logic [7:0]  ADJ_LO       = 8'h06;
    localparam logic [7:0]  ADJ_HI       = 8'h60;
    localparam logic [7:0]  SUB_LO       = 8'hFA;
    localparam logic [7:0]  SUB_HI       = 8'hA0;
    localparam logic [7:0]  SUB_BOTH     = 8'h9A;
    localparam logic [7:0]  BYTE_ONE     = 8'h01;
    localparam logic [15:0] WORD_ONE     = 16'h0001;
    localparam logic [7:0]  BYTE_MINNEG  = 8'h80;
    localparam logic [15:0] WORD_MINNEG  = 16'h8000;

    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

endpackage

// ---- rtl/bda_core.sv ----
/*
 * Combinational arithmetic of the unit: decimal adjust of a byte,
 * byte decrement and word decrement, with the new flag byte.
 * Assumes the caller registers the result and the flags.
 */
`timescale 1ns/1ns
module bda_core
    import bda_pkg::*;
(
    input  wire bda_op_t     op,
    input  wire logic [15:0] opnd,
    input  wire logic [7:0]  flags_in,
    output logic      [15:0] result,
    output logic      [7:0]  flags_out
);

    // ************************************************************
    // Decimal adjust correction
    // ************************************************************
    logic [3:0] lo_dig;
    logic [3:0] hi_dig;
    logic       lo_big;
    logic       hi_big;
    logic       add_lo;
    logic       add_hi;
    logic [7:0] corr;
    logic [7:0] da_byte;

    assign lo_dig = opnd[3:0];
    assign hi_dig = opnd[7:4];
    assign lo_big = lo_dig > DIGIT_MAX;
    assign hi_big = hi_dig > DIGIT_MAX;
    // Sum path: high digit 9 with a big low digit also overflows
    assign add_lo = lo_big | flags_in[FLG_H];
    assign add_hi = flags_in[FLG_C] | hi_big
                  | ((hi_dig == DIGIT_MAX) & lo_big);

    // D flag tells the last operation was a difference
    always_comb begin
        if (flags_in[FLG_D]) begin
            unique case ({flags_in[FLG_C], flags_in[FLG_H]})
                2'b01:   corr = SUB_LO;
                2'b10:   corr = SUB_HI;
                2'b11:   corr = SUB_BOTH;
                default: corr = ADJ_NONE;
            endcase
        end else begin
            corr = (add_lo ? ADJ_LO : ADJ_NONE)
                 | (add_hi ? ADJ_HI : ADJ_NONE);
        end
    end

    // Operand outside packed digits gives garbage, by design
    assign da_byte = opnd[7:0] + corr;

    // ************************************************************
    // Result and flag selection
    // ************************************************************
    always_comb begin
        result    = opnd;
        flags_out = flags_in;
        unique case (op)
            OP_DECIMAL_ADJUST: begin
                result[7:0]      = da_byte;
                // Carry follows the added 60, or is kept on subtract
                flags_out[FLG_C] = flags_in[FLG_D] ?
                                   flags_in[FLG_C] : add_hi;
                flags_out[FLG_Z] = (da_byte == ADJ_NONE);
                flags_out[FLG_S] = da_byte[7];
            end
            OP_BYTE_MINUS_ONE_OP: begin
                result[7:0]      = opnd[7:0] - BYTE_ONE;
                flags_out[FLG_Z] = (opnd[7:0] == BYTE_ONE);
                flags_out[FLG_S] = result[7];
                flags_out[FLG_V] = (opnd[7:0] == BYTE_MINNEG);
            end
            default: begin
                result           = opnd - WORD_ONE;
                flags_out[FLG_Z] = (opnd == WORD_ONE);
                flags_out[FLG_S] = result[15];
                flags_out[FLG_V] = (opnd == WORD_MINNEG);
            end
        endcase
    end

endmodule

// ---- test/bda_unit_assertions.sv ----
/*
 * Checker for the ports of bda_unit: execute timing and bus answers.
 * Assumes bda_pkg is compiled first; bound to every bda_unit below.
 */
`timescale 1ns/1ns
module bda_unit_checker
    import bda_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              busy,
    input wire logic              done
);
    // ********************
    // Helper decode
    // ********************
    wire aw_go  = s_axi_awvalid && s_axi_awready;
    wire w_go   = s_axi_wvalid && s_axi_wready;
    wire cmd_go = aw_go && w_go && s_axi_awaddr == ADDR_CMD && s_axi_wstrb[0];
    wire ill    = s_axi_wdata[1:0] == OP_ILLEGAL;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ********************
    // Properties
    // ********************
    property p_exec_pulse;
        busy |=> !busy && done;
    endproperty
    property p_done_cause;
        done |-> $past(busy);
    endproperty
    property p_cmd_runs;
        cmd_go && !ill |-> ##[1:3] busy;
    endproperty
    property p_cmd_bad;
        cmd_go && ill |=> !busy [*3];
    endproperty
    property p_b_after;
        aw_go && w_go |-> ##[1:2] s_axi_bvalid;
    endproperty
    // Writes above ADDR_STATUS must answer with an error, never silently
    property p_w_err;
        aw_go && w_go && s_axi_awaddr > ADDR_STATUS
            |-> ##[1:2] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endproperty
    property p_r_after;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_r_err;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > ADDR_STATUS
            |=> s_axi_rresp == RESP_SLVERR;
    endproperty
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty

    a_exec_pulse: assert property (p_exec_pulse)
        else $error("busy not followed by one done");
    a_done_cause: assert property (p_done_cause)
        else $error("done without busy");
    a_cmd_runs: assert property (p_cmd_runs)
        else $error("command did not start");
    a_cmd_bad: assert property (p_cmd_bad)
        else $error("illegal command started");
    a_b_after: assert property (p_b_after)
        else $error("write answer late");
    a_w_err: assert property (p_w_err)
        else $error("unmapped write not refused");
    a_r_after: assert property (p_r_after)
        else $error("read answer late");
    a_r_err: assert property (p_r_err)
        else $error("unmapped read not refused");
    a_b_block: assert property (p_b_block)
        else $error("write taken while answer pending");

    c_exec: cover property (busy);
    c_rerr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_wdone: cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind bda_unit bda_unit_checker u_chk (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .busy, .done
);

// ---- test/bda_seq_model.sv ----
/*
 * Sequencer model: bus master that feeds operands and commands.
 * Assumes the bench calls wr and rd one at a time, after reset.
 */
`timescale 1ns/1ns
module bda_seq_model (
    input  wire logic        aclk,
    output logic      [7:0]  s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic      [31:0] s_axi_wdata,
    output logic      [3:0]  s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic      [7:0]  s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    // Idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end

    // Ready is judged at the negedge: it equals what the next edge sees
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            ta = ta || (s_axi_awvalid && s_axi_awready);
            tw = tw || (s_axi_wvalid && s_axi_wready);
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            s_axi_awaddr <= ta ? ~a : a; // Released payload goes stale
            s_axi_wdata  <= tw ? ~d : d;
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
endmodule

// ---- test/bda_unit_test.sv ----
/*
 * Self-checking bench of bda_unit: table of operations, then registers,
 * errors and reset. Assumes bda_pkg, the checker and the model.
 */
`timescale 1ns/1ns
module bda_unit_test
    import bda_pkg::*;
;
    typedef struct {
        logic [1:0]  op;
        logic [15:0] x;
        logic [7:0]  f;
        logic [15:0] r;
        logic [7:0]  g;
    } bda_row_t;

    // ********************
    // Cases: operand and flags in, result and flags out
    // ********************
    bda_row_t rows [18] = '{
        '{2'h0, 16'h123C, 8'h00, 16'h1242, 8'h00},
        '{2'h0, 16'h00A5, 8'h00, 16'h0005, 8'h80},
        '{2'h0, 16'h009A, 8'h00, 16'h0000, 8'hC0},
        '{2'h0, 16'h0021, 8'h14, 16'h0027, 8'h14},
        '{2'h0, 16'h0015, 8'h80, 16'h0075, 8'h80},
        '{2'h0, 16'h0031, 8'h08, 16'h0031, 8'h08},
        '{2'h0, 16'h000F, 8'h0C, 16'h0009, 8'h0C},
        '{2'h0, 16'h00F0, 8'h88, 16'h0090, 8'hA8},
        '{2'h0, 16'h00FF, 8'h8C, 16'h0099, 8'hAC},
        '{2'h1, 16'h5503, 8'h8C, 16'h5502, 8'h8C},
        '{2'h1, 16'hAA00, 8'h00, 16'hAAFF, 8'h20},
        '{2'h1, 16'h0080, 8'h70, 16'h007F, 8'h10},
        '{2'h1, 16'h0001, 8'h00, 16'h0000, 8'h40},
        '{2'h2, 16'h1234, 8'h84, 16'h1233, 8'h84},
        '{2'h2, 16'h0100, 8'h00, 16'h00FF, 8'h00},
        '{2'h2, 16'h0000, 8'h00, 16'hFFFF, 8'h20},
        '{2'h2, 16'h8000, 8'h00, 16'h7FFF, 8'h10},
        '{2'h2, 16'h0001, 8'h60, 16'h0000, 8'h40}
    };

    logic              aclk, aresetn, busy, done;
    logic [7:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata, rd_v;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic              s_axi_rready;
    int                bad_count = 0;
    int                samples_checked = 0;
    int                done_seen = 0;

    bda_unit DUT (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .busy, .done
    );
    bda_seq_model u_seq (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    // Clock, and a count of completion pulses seen at the port
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) if (done === 1'b1) done_seen++;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] e);
        u_seq.wr(a, d, s, rsp);
        check({30'h0, rsp}, {30'h0, e});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        u_seq.rd(a, rd_v, rsp);
        check(rd_v, e);
        check({30'h0, rsp}, {30'h0, er});
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Run is a few hundred cycles; this only cuts a hang short
    initial begin
        #100000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report;
    end

    // ********************
    // Main sequence
    // ********************
    initial begin
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(ADDR_CMD, 32'h0, RESP_OKAY);
        rdc(ADDR_OPND, 32'h0, RESP_OKAY);
        rdc(ADDR_FLAGS, 32'h0, RESP_OKAY);
        rdc(ADDR_STATUS, 32'h0, RESP_OKAY);
        foreach (rows[i]) begin
            wrc(ADDR_OPND, {16'h0, rows[i].x}, 4'hF, RESP_OKAY);
            wrc(ADDR_FLAGS, {24'h0, rows[i].f}, 4'hF, RESP_OKAY);
            wrc(ADDR_CMD, {30'h0, rows[i].op}, 4'hF, RESP_OKAY);
            rdc(ADDR_OPND, {16'h0, rows[i].r}, RESP_OKAY);
            rdc(ADDR_FLAGS, {24'h0, rows[i].g}, RESP_OKAY);
        end
        check(32'(done_seen), 32'h12);
        rdc(ADDR_CMD, 32'h2, RESP_OKAY);
        rdc(ADDR_STATUS, 32'h2, RESP_OKAY);
        // Byte lanes: only lane 1 may change the operand
        wrc(ADDR_OPND, 32'h1234, 4'hF, RESP_OKAY);
        wrc(ADDR_OPND, 32'hFFFF_FF00, 4'h2, RESP_OKAY);
        rdc(ADDR_OPND, 32'hFF34, RESP_OKAY);
        wrc(ADDR_FLAGS, 32'hFF, 4'hF, RESP_OKAY);
        rdc(ADDR_FLAGS, 32'hFC, RESP_OKAY);
        // Illegal command, or one without lane 0, leaves the operand alone
        wrc(ADDR_CMD, 32'h3, 4'hF, RESP_OKAY);
        wrc(ADDR_CMD, 32'h1, 4'hE, RESP_OKAY);
        rdc(ADDR_STATUS, 32'h6, RESP_OKAY);
        rdc(ADDR_OPND, 32'hFF34, RESP_OKAY);
        wrc(ADDR_STATUS, 32'h7, 4'hF, RESP_OKAY);
        rdc(ADDR_STATUS, 32'h0, RESP_OKAY);
        wrc(8'h10, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        rdc(8'h10, 32'h0, RESP_SLVERR);
        rdc(ADDR_OPND, 32'hFF34, RESP_OKAY);
        // Second reset in mid-run clears the working registers
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(ADDR_OPND, 32'h0, RESP_OKAY);
        rdc(ADDR_FLAGS, 32'h0, RESP_OKAY);
        final_report;
    end
endmodule
